//--- bench/cmsd_checker_assertions.sv
// Purpose: Port relations of the clock mode select decoder.
// Assumes: One clock, synchronous active-low reset.
// Notes: Exact per-mode values are judged by the bench.
`timescale 1ns/10ps
module cmsd_checker (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // Inputs watched.
   input wire logic regWrStrobe,
   input wire logic inputRefLost,
   // Decoded controls.
   input wire logic cleaningLoopPowered,
   input wire logic synthesisLoopPowered,
   input wire logic cleaningRefSel,
   input wire logic holdTuning,
   input wire logic [1:0] blockSource,
   input wire logic [5:0] blockEnable,
   input wire logic [3:0] extraRouteEnable,
   input wire logic synthRefFromOsc,
   input wire logic cleaningFeedbackFromOutput,
   input wire logic synthFeedbackFromOutput,
   input wire logic feedbackExternal
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   // Paths move only two edges after a register write.
   property p_chg;
      $changed(blockSource) |-> $past(regWrStrobe, 2);
   endproperty
   a_chg: assert property (p_chg) else $error("path moved without a write");
   property p_ref;
      cleaningRefSel |-> cleaningLoopPowered;
   endproperty
   a_ref: assert property (p_ref) else $error("reference select with loop off");
   property p_blk;
      blockEnable inside {6'h00, 6'h3f};
   endproperty
   a_blk: assert property (p_blk) else $error("partial block enable");
   property p_extra;
      extraRouteEnable != 4'h0 |-> blockEnable == 6'h3f;
   endproperty
   a_extra: assert property (p_extra) else $error("extra route in bad mode");
   property p_hold;
      holdTuning |-> $past(inputRefLost);
   endproperty
   a_hold: assert property (p_hold) else $error("tuning held without loss");
   property p_cfb;
      cleaningFeedbackFromOutput |-> cleaningLoopPowered && synthesisLoopPowered;
   endproperty
   a_cfb: assert property (p_cfb) else $error("first loop feedback off mode");
   property p_single;
      synthRefFromOsc |-> !cleaningLoopPowered && synthesisLoopPowered;
   endproperty
   a_single: assert property (p_single) else $error("single loop wrong");
   property p_sfb;
      synthFeedbackFromOutput |-> synthRefFromOsc;
   endproperty
   a_sfb: assert property (p_sfb) else $error("second loop feedback off mode");
   property p_dist;
      blockSource == 2'h2 |-> !synthesisLoopPowered && blockEnable == 6'h3f;
   endproperty
   a_dist: assert property (p_dist) else $error("distribution wrong");
   property p_fbext;
      feedbackExternal |-> blockSource == 2'h0;
   endproperty
   a_fbext: assert property (p_fbext) else $error("external feedback with ext osc");

   // Main scenarios.
   c_m15: cover property (cleaningFeedbackFromOutput && blockSource == 2'h1);
   c_dist: cover property (blockSource == 2'h2);
   c_hold: cover property (holdTuning);
endmodule : cmsd_checker

bind cmsd_top cmsd_checker cmsd_checker_i (
   .clock(clock), .rst_b(rst_b), .regWrStrobe(regWrStrobe), .inputRefLost(inputRefLost),
   .cleaningLoopPowered(cleaningLoopPowered), .synthesisLoopPowered(synthesisLoopPowered),
   .cleaningRefSel(cleaningRefSel), .holdTuning(holdTuning), .blockSource(blockSource),
   .blockEnable(blockEnable), .extraRouteEnable(extraRouteEnable),
   .synthRefFromOsc(synthRefFromOsc), .cleaningFeedbackFromOutput(cleaningFeedbackFromOutput),
   .synthFeedbackFromOutput(synthFeedbackFromOutput), .feedbackExternal(feedbackExternal)
);

//--- bench/cmsd_host_model.sv
// Purpose: Host that programs the decoder registers.
// Assumes: Read data stands only in the cycle after the read strobe.
// Notes: Released lines flip, so a stale value never looks valid.
`timescale 1ns/10ps
module cmsd_host_model (
   // Clock.
   input wire logic clock,
   // Register port.
   output logic [4:0] regAddr,
   output logic [31:0] regWrData,
   output logic regWrStrobe,
   output logic regRdStrobe,
   input wire logic [31:0] regRdData
);
   // Idle bus at time zero.
   initial begin
      regAddr = 5'h00;
      regWrData = 32'h0;
      regWrStrobe = 1'b0;
      regRdStrobe = 1'b0;
   end

   // One write cycle; the strobe drops at the edge that takes it.
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrStrobe <= 1'b1;
      @(posedge clock);
      regWrStrobe <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~d;
   endtask : wr

   // One read cycle; the data is taken in the following cycle.
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge clock);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge clock);
      regRdStrobe <= 1'b0;
      regAddr <= ~a;
      #1;
      d = regRdData;
   endtask : rd

   // Mode 15 presets go in before the mode word, so the outputs start right.
   task automatic set_mode(input logic [4:0] m, input logic [31:0] aux);
      if (m == 5'h0f) begin
         wr(5'h14, 32'h0784e854);
         wr(5'h16, 32'h00000456);
      end else begin
         wr(5'h16, aux);
      end
      wr(5'h0b, {m, 27'h0});
   endtask : set_mode
endmodule : cmsd_host_model

//--- bench/tb_cmsd_top.sv
// Purpose: Self-checking bench for the clock mode select decoder.
// Assumes: The host model drives the register port.
// Notes: Expected paths are rebuilt from the mode table.
`timescale 1ns/10ps
module tb_cmsd_top;
   // Stimulus and wires.
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic inputRefLost = 1'b0;
   logic [4:0] regAddr;
   logic [31:0] regWrData, regRdData;
   logic regWrStrobe, regRdStrobe, cleaningLoopPowered, synthesisLoopPowered;
   logic cleaningRefSel, holdTuning, synthRefFromOsc, cleaningFeedbackFromOutput;
   logic synthFeedbackFromOutput, feedbackExternal, refout0Enable, refout1Enable;
   logic [1:0] blockSource;
   logic [5:0] blockEnable;
   logic [3:0] extraRouteEnable;
   int mismatches = 0;
   int samples_checked = 0;
   // Packed views for compact comparison.
   wire logic [31:0] seen = {13'h0, cleaningLoopPowered, synthesisLoopPowered,
      synthRefFromOsc, cleaningFeedbackFromOutput, synthFeedbackFromOutput, feedbackExternal,
      cleaningRefSel, blockSource, blockEnable, extraRouteEnable};
   wire logic [31:0] refs = {30'h0, refout1Enable, refout0Enable};

   always #2.5 clock = ~clock;

   cmsd_host_model cmsd_host_model_i (.clock(clock), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
      .regRdData(regRdData));
   cmsd_top cmsd_top_i (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
      .regRdData(regRdData), .inputRefLost(inputRefLost),
      .cleaningLoopPowered(cleaningLoopPowered), .synthesisLoopPowered(synthesisLoopPowered),
      .cleaningRefSel(cleaningRefSel), .holdTuning(holdTuning), .blockSource(blockSource),
      .blockEnable(blockEnable), .extraRouteEnable(extraRouteEnable),
      .synthRefFromOsc(synthRefFromOsc), .cleaningFeedbackFromOutput(cleaningFeedbackFromOutput),
      .synthFeedbackFromOutput(synthFeedbackFromOutput), .feedbackExternal(feedbackExternal),
      .refout0Enable(refout0Enable), .refout1Enable(refout1Enable));

   // Expected path word for a mode and an aux word.
   function automatic logic [31:0] expect_out(input logic [4:0] m, input logic [31:0] x);
      logic c, s, o, z, e, v;
      c = m inside {5'h00, 5'h02, 5'h03, 5'h0f};
      o = m inside {5'h06, 5'h08, 5'h0b};
      s = c | o;
      z = m inside {5'h02, 5'h08, 5'h0f};
      e = m inside {5'h03, 5'h0b, 5'h0f};
      v = s | (m == 5'h10);
      return {13'h0, c, s, o, z & c, z & ~c, z & ~e & x[0], c & x[1],
         (m == 5'h10) ? 2'h2 : {1'b0, e}, v ? 6'h3f : 6'h00, v ? x[7:4] : 4'h0};
   endfunction : expect_out

   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Let the edge's updates land before sampling.
   task automatic look();
      @(posedge clock);
      #1;
   endtask : look

   task automatic t_reset();
      logic [31:0] d;
      look();
      check("refouts", refs, 32'h1);
      check("paths", seen, expect_out(5'h00, 32'h0));
      cmsd_host_model_i.rd(5'h0a, d);
      check("outctrl", d, 32'h00400000);
      cmsd_host_model_i.rd(5'h14, d);
      check("refpd", d, 32'h0);
      cmsd_host_model_i.wr(5'h05, 32'hffffffff);
      cmsd_host_model_i.rd(5'h05, d);
      check("unmapped", d, 32'h0);
   endtask : t_reset

   // Every listed mode, then a reserved one.
   task automatic t_modes();
      logic [4:0] ml [9] = '{5'h00, 5'h02, 5'h03, 5'h06, 5'h08, 5'h0b, 5'h0f, 5'h10, 5'h01};
      logic [31:0] x;
      for (int i = 0; i < 9; i++) begin
         x = (ml[i] == 5'h0f) ? 32'h456 : 32'ha3;
         cmsd_host_model_i.set_mode(ml[i], x);
         look();
         check("paths", seen, expect_out(ml[i], x));
      end
   endtask : t_modes

   // Reference output controls move between registers in mode 15.
   task automatic t_refout();
      logic [31:0] d;
      cmsd_host_model_i.set_mode(5'h0f, 32'h0);
      look();
      check("refouts", refs, 32'h0);
      cmsd_host_model_i.rd(5'h1f, d);
      check("status", d, 32'h5f);
      cmsd_host_model_i.wr(5'h14, 32'h0704e854);
      look();
      check("refouts", refs, 32'h1);
      cmsd_host_model_i.wr(5'h14, 32'h0684e854);
      look();
      check("refouts", refs, 32'h2);
      cmsd_host_model_i.wr(5'h0a, 32'h00c00000);
      look();
      check("refouts", refs, 32'h2);
      cmsd_host_model_i.set_mode(5'h00, 32'h0);
      look();
      check("refouts", refs, 32'h3);
      cmsd_host_model_i.wr(5'h0a, 32'h00400000);
      look();
      check("refouts", refs, 32'h1);
   endtask : t_refout

   // Loss only freezes tuning with holdover on and the first loop running.
   task automatic t_hold();
      @(posedge clock);
      inputRefLost <= 1'b1;
      look();
      check("hold", {31'h0, holdTuning}, 32'h0);
      cmsd_host_model_i.wr(5'h0c, 32'h1);
      look();
      check("hold", {31'h0, holdTuning}, 32'h1);
      cmsd_host_model_i.set_mode(5'h06, 32'h0);
      look();
      check("hold", {31'h0, holdTuning}, 32'h0);
      @(posedge clock);
      inputRefLost <= 1'b0;
   endtask : t_hold

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      t_reset();
      t_modes();
      t_refout();
      t_hold();
      wrap_up();
   end

   // The whole run needs about a hundred cycles.
   initial begin
      repeat (5000) @(posedge clock);
      mismatches++;
      wrap_up();
   end
endmodule : tb_cmsd_top

//--- rtl/cmsd_mode_decode.sv
// Purpose: Turn the 5-bit mode field into loop and path controls.
// Assumes: Field is stable for a cycle before it is used.
// Notes: Purely combinational; the top registers the results.
`timescale 1ns/10ps
module cmsd_mode_decode (
   // Mode field in.
   input wire logic [4:0] modeField,
   // Decoded controls out.
   output logic cleaningLoopEn,
   output logic synthesisLoopEn,
   output logic extOscillator,
   output logic zeroDelay,
   output logic distributionOnly,
   output logic modeValid,
   output logic altRefoutMap
);

   // Table lookup of the supported encodings.
   always_comb begin
      cleaningLoopEn = 1'b0;
      synthesisLoopEn = 1'b0;
      extOscillator = 1'b0;
      zeroDelay = 1'b0;
      distributionOnly = 1'b0;
      modeValid = 1'b1;
      altRefoutMap = 1'b0;
      case (modeField)
         cmsd_pkg::MODE_DUAL: begin
            cleaningLoopEn = 1'b1;
            synthesisLoopEn = 1'b1;
         end
         cmsd_pkg::MODE_DUAL_ZD: begin
            cleaningLoopEn = 1'b1;
            synthesisLoopEn = 1'b1;
            zeroDelay = 1'b1;
         end
         cmsd_pkg::MODE_DUAL_EXT: begin
            cleaningLoopEn = 1'b1;
            synthesisLoopEn = 1'b1;
            extOscillator = 1'b1;
         end
         cmsd_pkg::MODE_SINGLE: begin
            synthesisLoopEn = 1'b1;
         end
         cmsd_pkg::MODE_SINGLE_ZD: begin
            synthesisLoopEn = 1'b1;
            zeroDelay = 1'b1;
         end
         cmsd_pkg::MODE_SINGLE_EXT: begin
            synthesisLoopEn = 1'b1;
            extOscillator = 1'b1;
         end
         cmsd_pkg::MODE_DUAL_ZD_EXT: begin
            cleaningLoopEn = 1'b1;
            synthesisLoopEn = 1'b1;
            extOscillator = 1'b1;
            zeroDelay = 1'b1;
            altRefoutMap = 1'b1;
         end
         cmsd_pkg::MODE_DIST: begin
            distributionOnly = 1'b1;
         end
         default: begin
            // Reserved codes: everything off, flagged invalid for software to see.
            modeValid = 1'b0;
         end
      endcase
   end

endmodule : cmsd_mode_decode

//--- rtl/cmsd_pkg.sv
// Purpose: Constants and types for the clock mode select decoder.
// Assumes: Registers are 32-bit words, reached by register index over a plain port.
// Notes: Register indices, field positions, reset values and mode codes for the design files live here.
//
// Contract
// - Decode mode field into loop, oscillator, zero-delay enables.
// - Dual loop: first loop uses input clock.
// - Internal oscillator drives six blocks, twelve outputs.
// - Reference outputs buffer oscillator, optionally four outputs.
// - Holdover freezes first loop tuning on loss.
// - Zero-delay dual loop feeds output to first loop.
// - Single loop powers first loop down.
// - Zero-delay single loop feeds output to second loop.
// - Distribution drives blocks from second input clock.
// - Mode 15: register 20 bit 23 powers down refout0.
// - Mode 15: register 20 bit 24 powers down refout1.
// - Other modes: register 10 bit 22 enables refout0.
// - Other modes: register 10 bit 23 enables refout1.
package cmsd_pkg;

   // Register indices; byte address is four times the index.
   localparam logic [4:0] REG_IDX_OUTCTRL = 5'h0a;
   localparam logic [4:0] REG_IDX_MODE = 5'h0b;
   localparam logic [4:0] REG_IDX_HOLDOVER = 5'h0c;
   localparam logic [4:0] REG_IDX_REFPD = 5'h14;
   localparam logic [4:0] REG_IDX_AUX = 5'h16;
   localparam logic [4:0] REG_IDX_STATUS = 5'h1f;

   // Field positions.
   localparam int MODE_LSB = 27;
   localparam int REFOUT0_EN_BIT = 22;
   localparam int REFOUT1_EN_BIT = 23;
   localparam int REFOUT0_PD_BIT = 23;
   localparam int REFOUT1_PD_BIT = 24;
   localparam int FB_EXT_BIT = 0;
   localparam int HOLDOVER_EN_BIT = 0;
   localparam int EXTRA_ROUTE_LSB = 4;

   // Reset values.
   localparam logic [31:0] OUTCTRL_RESET = 32'h0040_0000;
   localparam logic [31:0] MODE_RESET = 32'h0000_0000;
   localparam logic [31:0] HOLDOVER_RESET = 32'h0000_0000;
   localparam logic [31:0] REFPD_RESET = 32'h0000_0000;
   localparam logic [31:0] AUX_RESET = 32'h0000_0000;

   // Encoded mode values.
   localparam logic [4:0] MODE_DUAL = 5'h00;
   localparam logic [4:0] MODE_DUAL_ZD = 5'h02;
   localparam logic [4:0] MODE_DUAL_EXT = 5'h03;
   localparam logic [4:0] MODE_SINGLE = 5'h06;
   localparam logic [4:0] MODE_SINGLE_ZD = 5'h08;
   localparam logic [4:0] MODE_SINGLE_EXT = 5'h0b;
   localparam logic [4:0] MODE_DUAL_ZD_EXT = 5'h0f;
   localparam logic [4:0] MODE_DIST = 5'h10;

   // Counts of divide/delay blocks and general outputs.
   localparam int NUM_BLOCKS = 6;
   localparam int NUM_OUTPUTS = 12;
   localparam int NUM_EXTRA_ROUTE = 4;

   // Source feeding the divide/delay blocks.
   typedef enum logic [1:0] {
      SRC_INT_OSC,
      SRC_EXT_OSC,
      SRC_INPUT_B
   } cmsd_src_t;

   // Reference selection for the first loop.
   typedef enum logic {
      REF_INPUT_A,
      REF_INPUT_B
   } cmsd_ref_t;

endpackage : cmsd_pkg

//--- rtl/cmsd_refout_map.sv
// Purpose: Resolve one reference output enable from its two possible controls.
// Assumes: Caller selects the mode 15 mapping.
// Notes: One instance per reference output.
`timescale 1ns/10ps
module cmsd_refout_map (
   // Mapping select.
   input wire logic altMap,
   // Candidate controls.
   input wire logic enableBit,
   input wire logic powerdownBit,
   // Resolved enable.
   output logic outEnable
);

   // In the alternate mapping the bit is a powerdown, so its sense inverts.
   always_comb begin
      outEnable = altMap ? ~powerdownBit : enableBit;
   end

endmodule : cmsd_refout_map

//--- rtl/cmsd_top.sv
// Purpose: Clock mode select decoder with its configuration registers.
// Assumes: Plain register port, read data one cycle after the read strobe.
// Notes: Outputs are registered path selections for the analog clock paths.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
module cmsd_top (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // Register port.
   input wire logic [4:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrStrobe,
   input wire logic regRdStrobe,
   output logic [31:0] regRdData,
   // Reference status from the first loop.
   input wire logic inputRefLost,
   // Loop controls.
   output logic cleaningLoopPowered,
   output logic synthesisLoopPowered,
   output logic cleaningRefSel,
   output logic holdTuning,
   // Oscillator and distribution paths.
   output logic [1:0] blockSource,
   output logic [5:0] blockEnable,
   output logic [3:0] extraRouteEnable,
   output logic synthRefFromOsc,
   // Zero-delay feedback.
   output logic cleaningFeedbackFromOutput,
   output logic synthFeedbackFromOutput,
   output logic feedbackExternal,
   // Reference outputs.
   output logic refout0Enable,
   output logic refout1Enable
);

   // Overview: five configuration words live here and
   // the mode field is decoded into loop and path
   // controls. Every control that leaves the block
   // comes from a flip-flop, so a write reaches the
   // outputs two edges after its strobe.
   // Software ordering, such as presetting the mode 15
   // words, is not enforced: each word simply takes
   // effect on its own write.

   // Configuration registers.
   // Whole words are kept, so software reads back
   // what it wrote, unused bits included.
   logic [31:0] outctrl_reg;
   logic [31:0] mode_reg;
   logic [31:0] holdover_reg;
   logic [31:0] refpd_reg;
   logic [31:0] aux_reg;

   // Mode field taken from the mode word.
   logic [4:0] modeField;

   // Loop enables from the decoder.
   logic cleaningLoopEn;
   logic synthesisLoopEn;

   // Path flags from the decoder.
   logic extOscillator;
   logic zeroDelay;
   logic distributionOnly;

   // Legality and reference output mapping.
   logic modeValid;
   logic altRefoutMap;

   // Resolved reference output enables.
   // They are registered below, so a mode write
   // never glitches the output buffers.
   logic refout0Next;
   logic refout1Next;

   // Read data next value.
   // Kept apart so the read register has one source.
   logic [31:0] regRdData_next;

   // The mode field is the top five bits of its word.
   // Taking it here keeps the decoder free of the
   // register layout.
   assign modeField = mode_reg[cmsd_pkg::MODE_LSB +: 5];

   // Write path for the configuration registers.
   // A write takes one cycle and the port never
   // stalls, so there is no busy state to track.
   // Bits this block does not decode are still kept.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         // Power-on values; mode 0 is the dual loop.
         outctrl_reg <= cmsd_pkg::OUTCTRL_RESET;
         mode_reg <= cmsd_pkg::MODE_RESET;
         holdover_reg <= cmsd_pkg::HOLDOVER_RESET;
         refpd_reg <= cmsd_pkg::REFPD_RESET;
         aux_reg <= cmsd_pkg::AUX_RESET;
      end else if (regWrStrobe) begin
         // Each register takes effect on its own write, so presetting the
         // alternate map before the mode write leaves the outputs clean.
         case (regAddr)
            cmsd_pkg::REG_IDX_OUTCTRL: begin
               // Normal-mode reference output enables.
               outctrl_reg <= regWrData;
            end

            cmsd_pkg::REG_IDX_MODE: begin
               // The new mode reaches the pins a cycle later.
               mode_reg <= regWrData;
            end

            cmsd_pkg::REG_IDX_HOLDOVER: begin
               // Bit zero arms the tuning freeze.
               holdover_reg <= regWrData;
            end

            cmsd_pkg::REG_IDX_REFPD: begin
               // Mode 15 reference output powerdowns.
               refpd_reg <= regWrData;
            end

            cmsd_pkg::REG_IDX_AUX: begin
               // Feedback pin, reference select, routes.
               aux_reg <= regWrData;
            end
            default: begin
               // Unmapped writes are dropped.
            end
         endcase
      end
   end

   // Mode decoder.
   // It is combinational; all it feeds is registered
   // here, so a code seen for one cycle during a write
   // cannot reach the pins half-formed.
   cmsd_mode_decode uDecode (
      .modeField(modeField),
      .cleaningLoopEn(cleaningLoopEn),
      .synthesisLoopEn(synthesisLoopEn),
      .extOscillator(extOscillator),
      .zeroDelay(zeroDelay),
      .distributionOnly(distributionOnly),
      .modeValid(modeValid),
      .altRefoutMap(altRefoutMap)
   );

   // Reference output 0 mapping.
   // Mode 15 moves the control to the powerdown word
   // and flips its sense; the mapper hides both.
   cmsd_refout_map uRefout0 (
      .altMap(altRefoutMap),
      .enableBit(outctrl_reg[cmsd_pkg::REFOUT0_EN_BIT]),
      .powerdownBit(refpd_reg[cmsd_pkg::REFOUT0_PD_BIT]),
      .outEnable(refout0Next)
   );

   // Reference output 1 mapping.
   // Same rule as output 0, one bit higher.
   cmsd_refout_map uRefout1 (
      .altMap(altRefoutMap),
      .enableBit(outctrl_reg[cmsd_pkg::REFOUT1_EN_BIT]),
      .powerdownBit(refpd_reg[cmsd_pkg::REFOUT1_PD_BIT]),
      .outEnable(refout1Next)
   );

   // Loop power and reference selection.
   // All but the reference select follows the decoded mode alone, so a
   // reserved code powers both loops down.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         // Both loops stay off while reset is held.
         cleaningLoopPowered <= 1'b0;
         synthesisLoopPowered <= 1'b0;
         cleaningRefSel <= 1'b0;
         synthRefFromOsc <= 1'b0;
      end else begin
         // Single loop and distribution leave the first loop powered down.
         cleaningLoopPowered <= cleaningLoopEn;
         // The second loop runs in every loop mode.
         synthesisLoopPowered <= synthesisLoopEn;
         // First loop takes input clock a or b; the choice is a control bit.
         // The select is forced low while that loop is off.
         cleaningRefSel <= cleaningLoopEn & aux_reg[1];
         // Without the first loop the oscillator input feeds the second loop.
         synthRefFromOsc <= synthesisLoopEn & ~cleaningLoopEn;
      end
   end

   // Holdover freezes the tuning voltage only when the first loop runs.
   // Loss is taken as a level; the freeze lifts one
   // cycle after the reference returns.
   // Limitation: short losses are not filtered.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         // No freeze out of reset.
         holdTuning <= 1'b0;
      end else begin
         // Needs the loop, the arm bit and a loss.
         holdTuning <= cleaningLoopEn & holdover_reg[cmsd_pkg::HOLDOVER_EN_BIT]
            & inputRefLost;
      end
   end

   // Divide/delay block source and enables.
   // Distribution wins over the oscillator choice,
   // as that mode has no loop to drive the blocks.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         // Internal oscillator, all blocks stopped.
         blockSource <= 2'(cmsd_pkg::SRC_INT_OSC);
         blockEnable <= 6'h00;
         extraRouteEnable <= 4'h0;
      end else begin
         if (distributionOnly) begin
            // Second input clock drives the blocks.
            blockSource <= 2'(cmsd_pkg::SRC_INPUT_B);
         end else if (extOscillator) begin
            // External oscillator replaces the internal one.
            blockSource <= 2'(cmsd_pkg::SRC_EXT_OSC);
         end else begin
            // Internal oscillator, the usual case.
            blockSource <= 2'(cmsd_pkg::SRC_INT_OSC);
         end
         // All six blocks run in any valid mode; reserved codes stop them.
         // Stopping is safer than guessing a source.
         blockEnable <= modeValid ? 6'h3f : 6'h00;
         // Oscillator may also reach up to four general outputs.
         // Reserved codes mask these routes as well.
         extraRouteEnable <= modeValid ?
            aux_reg[cmsd_pkg::EXTRA_ROUTE_LSB +: cmsd_pkg::NUM_EXTRA_ROUTE] : 4'h0;
      end
   end

   // Zero-delay feedback routing.
   // Which loop is fed follows from whether the
   // first loop runs at all.
   // Aux bit zero picks the external feedback pin.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         // No feedback path out of reset.
         cleaningFeedbackFromOutput <= 1'b0;
         synthFeedbackFromOutput <= 1'b0;
         feedbackExternal <= 1'b0;
      end else begin
         // Dual-loop zero-delay feeds the first loop.
         cleaningFeedbackFromOutput <= zeroDelay & cleaningLoopEn;
         // Single-loop zero-delay feeds the second loop.
         synthFeedbackFromOutput <= zeroDelay & ~cleaningLoopEn;
         // The external feedback pin is taken by an external oscillator.
         // Forcing internal feedback then guards the pin.
         feedbackExternal <= zeroDelay & ~extOscillator
            & aux_reg[cmsd_pkg::FB_EXT_BIT];
      end
   end

   // Reference output enables.
   // Out of reset output 0 runs and output 1 is off,
   // as in the normal-mode power-on values.
   // Trade-off: a cycle of delay buys clean outputs
   // when the mapping changes with the mode.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         // Power-on state of the two outputs.
         refout0Enable <= 1'b1;
         refout1Enable <= 1'b0;
      end else begin
         // Follow the mapped controls.
         refout0Enable <= refout0Next;
         refout1Enable <= refout1Next;
      end
   end

   // Read multiplexer; status word shows decoded state.
   // The status word is read-only; a write to it falls
   // into the dropped default of the write path.
   // Unmapped indices read as zero.
   always_comb begin
      regRdData_next = 32'h0000_0000;
      case (regAddr)
         cmsd_pkg::REG_IDX_OUTCTRL: regRdData_next = outctrl_reg;
         cmsd_pkg::REG_IDX_MODE: regRdData_next = mode_reg;
         cmsd_pkg::REG_IDX_HOLDOVER: regRdData_next = holdover_reg;
         cmsd_pkg::REG_IDX_REFPD: regRdData_next = refpd_reg;
         cmsd_pkg::REG_IDX_AUX: regRdData_next = aux_reg;
         cmsd_pkg::REG_IDX_STATUS: begin
            // Decoded flags in the low ten bits.
            regRdData_next = {22'h000000, refout1Enable, refout0Enable, holdTuning,
               modeValid, distributionOnly, zeroDelay, extOscillator,
               synthesisLoopEn, cleaningLoopEn, altRefoutMap};
         end
         default: regRdData_next = 32'h0000_0000;
      endcase
   end

   // Read data stand for one cycle after the strobe, zero otherwise.
   // Zero between reads keeps a stale word from
   // passing for a fresh answer.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         // Nothing to show out of reset.
         regRdData <= 32'h0000_0000;
      end else begin
         // Hold the word only after a read strobe.
         regRdData <= regRdStrobe ? regRdData_next : 32'h0000_0000;
      end
   end

endmodule : cmsd_top
